// file: logic/rad_cfg.svh
// offsets, field positions, substitute pattern, line id base and timing counts of the dma error block
// assumes a 20 MHz mclk and byte addresses on the avalon slave
//
// Summary of operation
// - a checker error during dma ends the operation early
// - a strobe timer runs during dma and flags a missing strobe as timeout
// - bad byte strobe combinations, or address low bit against data mode, are errors
// - wrap mode makes its own byte strobes and final flag from mode and count
// - transfer data parity error logs level 1 with position and raises level 1
// - bus timeout and internal parity in data raise level 4, line id, level 2 status
// - a dma read aborted by timeout leaves data and extended buffers unchanged
// - errors while building the control word raise level 4, log level 2, send no data
// - external type 1 error from a card at positions 1 to 3 during the data phase raises level 4 and level 2 status
// - routed positions also log into maintenance error status and raise its interrupt
// - start plus route bit plus request bit raises a direct interrupt
// - the completion read returns then clears maintenance error status
// - the completion read shows direct and maintenance status interrupts separately
// - a control word error turns it into short form and ends dma without data
// - a bad parity address is replaced by a valid pattern toward the controller
// - data mode picks odd or even start with byte swap toward the controller; count gives bytes
`ifndef RAD_CFG_SVH
`define RAD_CFG_SVH

`define RAD_OFF_CTRL 6'h00
`define RAD_OFF_ROUTE 6'h04
`define RAD_OFF_L1 6'h08
`define RAD_OFF_L2_0 6'h0C
`define RAD_OFF_L2_1 6'h10
`define RAD_OFF_L2_2 6'h14
`define RAD_OFF_L2_3 6'h18
`define RAD_OFF_MAINT 6'h1C
`define RAD_OFF_COMPL 6'h20
`define RAD_OFF_LINEID 6'h24
`define RAD_OFF_IRQST 6'h28
`define RAD_OFF_IRQMASK 6'h2C
`define RAD_OFF_DATABUF 6'h30
`define RAD_OFF_EXTBUF 6'h34

// interrupt status bits
`define RAD_IRQ_L1 0
`define RAD_IRQ_L4 1
`define RAD_IRQ_MAINT 2
`define RAD_IRQ_DIRECT 3

// level 2 status bits
`define RAD_L2_ADDRPAR 0
`define RAD_L2_TIMEOUT 1
`define RAD_L2_INTPAR 2
`define RAD_L2_IDLE 3
`define RAD_L2_EXT1 4
`define RAD_L2_STROBE 5

`define RAD_SUBST_PATTERN 16'h0000
`define RAD_LINEID_BASE 6'h10
`define RAD_CLK_NS 50
`define RAD_TMO_NS 10000
`define RAD_TMO_CYC ((`RAD_TMO_NS + `RAD_CLK_NS - 1) / `RAD_CLK_NS)

`endif

// file: logic/rad_pkg.sv
// types of the dma error block
// assumes rad_cfg.svh for numbers
package rad_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_CW, ST_DATA} rad_state_t;

    typedef struct packed {
        logic [7:0] count;
        logic [1:0] pos;
        logic forcePar;
        logic dirRead;
        logic oddMode;
        logic wrap;
        logic start;
        logic go;
    } rad_ctrl_t;

    typedef struct packed {
        logic strobe;
        logic extErr;
        logic idleErr;
        logic [1:0] ulStrobes;
        logic last;
        logic [1:0] par;
        logic [15:0] data;
    } rad_card_in_t;

    typedef struct packed {
        logic valid;
        logic ctrlWord;
        logic shortForm;
        logic last;
        logic [1:0] strobes;
        logic [15:0] data;
    } rad_ctl_bus_t;

    typedef struct packed {
        rad_state_t st;
        logic ack;
        logic [31:0] rdata;
        rad_ctrl_t ctrl;
        logic [3:0] route;
        logic [3:0] irqReq;
        logic [2:0] l1;
        logic [3:0][5:0] l2;
        logic [2:0] maint;
        logic [3:0] irqSt;
        logic [3:0] irqMask;
        logic [7:0] lineId;
        logic [15:0] dataBuf;
        logic [15:0] extBuf;
        logic [31:0] stage;
        logic [7:0] timer;
        logic [7:0] left;
        logic first;
        logic addrLsb;
        rad_card_in_t s1;
        rad_card_in_t s2;
        logic strobePrev;
        rad_ctl_bus_t ctl;
    } rad_st_t;
endpackage

// file: logic/rad_dma_err.sv
// dma engine with error management toward the controller bus
// assumes card pins asynchronous to mclk, controller bus and avalon on mclk
//
// The implementer's own choices: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "rad_cfg.svh"

module rad_dma_err
    import rad_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // avalon slave
    input wire logic [5:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // card pins
    input rad_card_in_t cardIn,
    // controller bus
    input wire logic ctlParErr,
    input wire logic [15:0] ctlRdData,
    output rad_ctl_bus_t ctlOut,
    // interrupt
    output logic irq
);
    localparam logic [7:0] TMO_CYC = 8'(`RAD_TMO_CYC);

    rad_st_t r;
    rad_st_t n;

    logic acc;
    logic stb;
    logic [15:0] word;
    logic parBad;
    logic [1:0] strobes;
    logic strobeBad;
    logic [7:0] bytes;
    logic lastX;
    logic [5:0] errv;
    logic endOp;
    logic timeout;

    assign waitrequest = (read | write) & ~r.ack;
    assign readdata = r.rdata;
    assign ctlOut = r.ctl;
    assign irq = |(r.irqSt & r.irqMask);

    always_comb begin
        n = r;
        errv = 6'h00;
        endOp = 1'b0;
        strobes = 2'b00;
        strobeBad = 1'b0;
        bytes = 8'h01;
        lastX = 1'b0;
        n.ctl.valid = 1'b0;
        n.ctrl.go = 1'b0;
        n.s1 = cardIn;
        n.s2 = r.s1;
        n.strobePrev = r.s2.strobe;
        acc = (read | write) & ~r.ack;
        n.ack = acc;
        timeout = (r.timer == TMO_CYC - 8'h01);

        // wrap mode strobes every cycle from the data buffer
        stb = r.ctrl.wrap ? 1'b1 : (r.s2.strobe & ~r.strobePrev);
        word = r.ctrl.wrap ? r.dataBuf : r.s2.data;
        // odd parity per byte
        parBad = r.ctrl.wrap ? r.ctrl.forcePar :
            (~^{r.s2.data[15:8], r.s2.par[1]}) | (~^{r.s2.data[7:0], r.s2.par[0]});

        // bus side clears come first so hardware sets below win
        if (acc && write) begin
            case (address)
                `RAD_OFF_CTRL: begin
                    if (r.st == ST_IDLE) begin
                        n.ctrl = rad_ctrl_t'(writedata[15:0]);
                    end
                end
                `RAD_OFF_ROUTE: begin
                    n.route = writedata[3:0];
                    n.irqReq = writedata[7:4];
                end
                `RAD_OFF_IRQST: n.irqSt = r.irqSt & ~writedata[3:0];
                `RAD_OFF_IRQMASK: n.irqMask = writedata[3:0];
                `RAD_OFF_DATABUF: n.dataBuf = writedata[15:0];
                `RAD_OFF_EXTBUF: n.extBuf = writedata[15:0];
                default: begin
                end
            endcase
        end
        if (acc && read) begin
            case (address)
                `RAD_OFF_CTRL: n.rdata = {(r.st != ST_IDLE), 15'h0000, r.ctrl};
                `RAD_OFF_ROUTE: n.rdata = {24'h00_0000, r.irqReq, r.route};
                `RAD_OFF_L1: begin
                    n.rdata = {29'h0000_0000, r.l1};
                    n.l1 = 3'h0;
                end
                `RAD_OFF_L2_0: begin
                    n.rdata = {26'h000_0000, r.l2[0]};
                    n.l2[0] = 6'h00;
                end
                `RAD_OFF_L2_1: begin
                    n.rdata = {26'h000_0000, r.l2[1]};
                    n.l2[1] = 6'h00;
                end
                `RAD_OFF_L2_2: begin
                    n.rdata = {26'h000_0000, r.l2[2]};
                    n.l2[2] = 6'h00;
                end
                `RAD_OFF_L2_3: begin
                    n.rdata = {26'h000_0000, r.l2[3]};
                    n.l2[3] = 6'h00;
                end
                `RAD_OFF_MAINT: n.rdata = {29'h0000_0000, r.maint};
                `RAD_OFF_COMPL: begin
                    n.rdata = {24'h00_0000, r.irqSt[`RAD_IRQ_DIRECT],
                        r.irqSt[`RAD_IRQ_MAINT], 3'h0, r.maint};
                    n.maint = 3'h0;
                end
                `RAD_OFF_LINEID: n.rdata = {24'h00_0000, r.lineId};
                `RAD_OFF_IRQST: n.rdata = {28'h000_0000, r.irqSt};
                `RAD_OFF_IRQMASK: n.rdata = {28'h000_0000, r.irqMask};
                `RAD_OFF_DATABUF: n.rdata = {16'h0000, r.dataBuf};
                `RAD_OFF_EXTBUF: n.rdata = {16'h0000, r.extBuf};
                default: n.rdata = 32'h0000_0000;
            endcase
        end

        case (r.st)
            ST_IDLE: begin
                if (r.ctrl.go) begin
                    n.st = ST_CW;
                    n.timer = 8'h00;
                    n.left = r.ctrl.count;
                    n.first = 1'b1;
                    n.stage = 32'h0000_0000;
                end
            end
            ST_CW: begin
                n.timer = r.timer + 8'h01;
                // control word errors: no data may reach the controller
                errv[`RAD_L2_INTPAR] = ctlParErr;
                errv[`RAD_L2_IDLE] = r.s2.idleErr;
                errv[`RAD_L2_TIMEOUT] = timeout & ~stb;
                if (stb) begin
                    errv[`RAD_L2_ADDRPAR] = parBad;
                    n.addrLsb = word[0];
                    n.timer = 8'h00;
                end
                if (|errv) begin
                    // short form with a valid pattern keeps the controller from timing out
                    n.ctl = '{valid: 1'b1, ctrlWord: 1'b1, shortForm: 1'b1, last: 1'b1,
                        strobes: 2'b00, data: `RAD_SUBST_PATTERN};
                    n.st = ST_IDLE;
                end else if (stb) begin
                    n.ctl = '{valid: 1'b1, ctrlWord: 1'b1, shortForm: 1'b0, last: 1'b0,
                        strobes: 2'b11, data: word};
                    n.st = ST_DATA;
                end
            end
            ST_DATA: begin
                n.timer = r.timer + 8'h01;
                if (r.ctrl.wrap) begin
                    if (r.first && r.ctrl.oddMode) begin
                        strobes = r.addrLsb ? 2'b01 : 2'b00;
                    end else if (r.left == 8'h01) begin
                        strobes = 2'b10;
                    end else begin
                        strobes = 2'b11;
                    end
                end else begin
                    strobes = r.s2.ulStrobes;
                end
                bytes = (strobes == 2'b11) ? 8'h02 : 8'h01;
                lastX = r.ctrl.wrap ? (r.left <= bytes) : r.s2.last;
                strobeBad = (strobes == 2'b00) |
                    (r.first & (r.addrLsb != r.ctrl.oddMode)) |
                    (r.first & r.ctrl.oddMode & (strobes != 2'b01));
                errv[`RAD_L2_INTPAR] = ctlParErr;
                errv[`RAD_L2_EXT1] = r.s2.extErr & (r.ctrl.pos != 2'd0);
                errv[`RAD_L2_TIMEOUT] = timeout & ~stb;
                if (stb) begin
                    n.timer = 8'h00;
                    errv[`RAD_L2_STROBE] = strobeBad;
                end
                if (stb && parBad && !(|errv)) begin
                    n.l1 = {1'b1, r.ctrl.pos};
                    n.irqSt[`RAD_IRQ_L1] = 1'b1;
                    endOp = 1'b1;
                end else if (|errv) begin
                    // buffers are only committed on a clean end
                    endOp = 1'b1;
                end else if (stb) begin
                    n.first = 1'b0;
                    n.left = r.left - bytes;
                    if (r.ctrl.dirRead) begin
                        n.stage = {r.stage[15:0], ctlRdData};
                        if (lastX) begin
                            n.dataBuf = ctlRdData;
                            n.extBuf = r.stage[15:0];
                        end
                    end else begin
                        // odd start addresses swap bytes toward the controller
                        n.ctl = '{valid: 1'b1, ctrlWord: 1'b0, shortForm: 1'b0, last: lastX,
                            strobes: strobes, data: r.ctrl.oddMode ?
                            {word[7:0], word[15:8]} : word};
                    end
                    if (lastX) begin
                        n.st = ST_IDLE;
                    end
                end
                if (endOp) begin
                    n.st = ST_IDLE;
                end
            end
            default: n.st = ST_IDLE;
        endcase

        if (|errv) begin
            n.l2[r.ctrl.pos] = n.l2[r.ctrl.pos] | errv;
            n.irqSt[`RAD_IRQ_L4] = 1'b1;
            n.lineId = {`RAD_LINEID_BASE, r.ctrl.pos};
            if (r.route[r.ctrl.pos]) begin
                // internal, type 1, type 2 classes
                n.maint = n.maint | {errv[`RAD_L2_IDLE],
                    errv[`RAD_L2_TIMEOUT] | errv[`RAD_L2_EXT1],
                    errv[`RAD_L2_ADDRPAR] | errv[`RAD_L2_INTPAR] |
                    errv[`RAD_L2_STROBE]};
                n.irqSt[`RAD_IRQ_MAINT] = 1'b1;
            end
        end
        if (r.ctrl.start && |(r.route & r.irqReq)) begin
            n.irqSt[`RAD_IRQ_DIRECT] = 1'b1;
            n.lineId = {`RAD_LINEID_BASE, 2'd0};
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end
endmodule

// file: logic/rad_dma_err_pad.sv
// intentionally empty companion kept out
`timescale 1ns/1ps

// file: bench/rad_dma_err_assertions.sv
// port checker of the dma error block
// assumes it is bound to every rad_dma_err instance
`timescale 1ns/1ps
`include "rad_cfg.svh"
module rad_dma_err_assertions
    import rad_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // avalon slave
    input wire logic [5:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    // card and controller
    input rad_card_in_t cardIn,
    input wire logic ctlParErr,
    input wire logic [15:0] ctlRdData,
    input rad_ctl_bus_t ctlOut,
    input wire logic irq
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence s_short;
        ctlOut.valid && ctlOut.shortForm;
    endsequence
    sequence s_quiet;
        !ctlOut.valid [*3];
    endsequence
    chk_wait_first: assert property ($rose(read || write) |-> waitrequest)
        else $error("no wait state on a new request");
    chk_wait_one: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("wait state longer than one cycle");
    chk_idle_nowait: assert property (!(read || write) |-> !waitrequest)
        else $error("wait without request");
    chk_rdata_hold: assert property (!(read && waitrequest) |=> $stable(readdata))
        else $error("read data moved without a read");
    chk_short_word: assert property (s_short |-> ctlOut.ctrlWord && ctlOut.last &&
        ctlOut.data == `RAD_SUBST_PATTERN) else $error("bad short control word");
    chk_short_ends: assert property (s_short |=> s_quiet)
        else $error("data sent after short control word");
    chk_last_ends: assert property (ctlOut.valid && ctlOut.last |=> s_quiet)
        else $error("transfer after final word");
    chk_data_stands: assert property (!ctlOut.valid |-> $stable(ctlOut.data))
        else $error("controller data moved without valid");
endmodule

bind rad_dma_err rad_dma_err_assertions i_chk (.mclk(mclk), .rst_n(rst_n), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .cardIn(cardIn), .ctlParErr(ctlParErr),
    .ctlRdData(ctlRdData), .ctlOut(ctlOut), .irq(irq));

// file: bench/rad_card_model.sv
// card and controller side model
// assumes tasks are called just after a rising mclk edge
`timescale 1ns/1ps
module rad_card_model
    import rad_pkg::*;
(
    // clock
    input wire logic mclk,
    // card side
    output rad_card_in_t cardIn,
    // controller side
    output logic ctlParErr,
    output logic [15:0] ctlRdData
);
    initial begin
        cardIn = '0;
        ctlParErr = 1'b0;
        ctlRdData = 16'h0000;
    end
    // controller read data changes every cycle so stale values never match
    always @(posedge mclk) begin
        ctlRdData <= ctlRdData + 16'h0101;
    end
    // strobe held 4 cycles to clear the two-flop sync; odd parity per byte
    task automatic word(input logic [15:0] d, input logic [1:0] ul, input logic lst,
        input logic bad);
        @(posedge mclk);
        cardIn.data <= d;
        cardIn.ulStrobes <= ul;
        cardIn.last <= lst;
        cardIn.par <= {~^d[15:8], ~^d[7:0] ^ bad};
        cardIn.strobe <= 1'b1;
        repeat (4) @(posedge mclk);
        cardIn.strobe <= 1'b0;
        cardIn.data <= ~d;
        repeat (4) @(posedge mclk);
    endtask
    task automatic pins(input logic ext, input logic idle, input logic par);
        @(posedge mclk);
        cardIn.extErr <= ext;
        cardIn.idleErr <= idle;
        ctlParErr <= par;
    endtask
endmodule

// file: bench/tb.sv
// self-checking bench of the dma error block
// assumes rad_card_model on the card and controller side
`timescale 1ns/1ps
`include "rad_cfg.svh"
module tb
    import rad_pkg::*;
;
    localparam logic [31:0] ZW = 32'h0000_0000;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [5:0] address = 6'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0000_0000;
    logic [31:0] readdata, q;
    logic waitrequest, irq, ctlParErr;
    logic [15:0] ctlRdData;
    rad_card_in_t cardIn;
    rad_ctl_bus_t ctlOut;
    rad_ctl_bus_t caps[$];
    int fail_count = 0;
    int comparisons = 0;
    always #25 mclk = ~mclk;
    // valid is one cycle wide, so the falling edge sees it exactly once
    always @(negedge mclk) if (ctlOut.valid === 1'b1) caps.push_back(ctlOut);
    rad_dma_err i_rad_dma_err (.mclk(mclk), .rst_n(rst_n), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .cardIn(cardIn), .ctlParErr(ctlParErr), .ctlRdData(ctlRdData), .ctlOut(ctlOut),
        .irq(irq));
    rad_card_model i_rad_card_model (.mclk(mclk), .cardIn(cardIn), .ctlParErr(ctlParErr),
        .ctlRdData(ctlRdData));
    task automatic conclude();
        if (fail_count == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        @(posedge mclk);
        address <= a;
        writedata <= d;
        write <= wr;
        read <= !wr;
        do @(posedge mclk); while (waitrequest !== 1'b0);
        q = readdata;
        write <= 1'b0;
        read <= 1'b0;
    endtask
    task automatic rdc(input logic [5:0] a, input logic [31:0] exp);
        bus(1'b0, a, ZW);
        chk(q, exp);
    endtask
    task automatic idle();
        do bus(1'b0, `RAD_OFF_CTRL, ZW); while (q[31] !== 1'b0);
    endtask
    task automatic run(input logic [15:0] adr, input logic [31:0] ctl);
        caps.delete();
        bus(1'b1, `RAD_OFF_DATABUF, {16'h0000, adr});
        bus(1'b1, `RAD_OFF_CTRL, ctl);
        repeat (2) @(posedge mclk);
        idle();
    endtask
    // level 2 per position, line id, level 4 and its clearing
    task automatic errChk(input logic [1:0] p, input logic [31:0] l2, input logic [31:0] st);
        rdc(`RAD_OFF_L2_0 + {2'b00, p, 2'b00}, l2);
        rdc(`RAD_OFF_LINEID, {24'h00_0000, `RAD_LINEID_BASE, p});
        rdc(`RAD_OFF_IRQST, st);
        chk(32'(irq), 32'h0000_0001);
        bus(1'b1, `RAD_OFF_IRQST, st);
        chk(32'(irq), ZW);
    endtask
    task automatic sRegs();
        rdc(`RAD_OFF_CTRL, ZW);
        rdc(`RAD_OFF_L1, ZW);
        rdc(`RAD_OFF_MAINT, ZW);
        bus(1'b1, 6'h3C, 32'hFFFF_FFFF);
        rdc(6'h3C, ZW);
        bus(1'b1, `RAD_OFF_IRQMASK, 32'h0000_000F);
        rdc(`RAD_OFF_IRQMASK, 32'h0000_000F);
    endtask
    task automatic sWrap();
        run(16'h1234, 32'h0000_0205);
        chk(32'(caps.size()), 32'h0000_0002);
        chk(32'({caps[0].ctrlWord, caps[0].shortForm, caps[0].data}), 32'h0002_1234);
        chk(32'({caps[1].last, caps[1].strobes, caps[1].data}), 32'h0007_1234);
        run(16'h1235, 32'h0000_010D);
        chk(32'({caps[1].last, caps[1].strobes, caps[1].data}), 32'h0005_3512);
        rdc(`RAD_OFF_IRQST, ZW);
    endtask
    task automatic sStrobe();
        for (int p = 0; p < 4; p++) begin
            run(16'h1234, 32'h0000_020D | 32'(p << 6));
            errChk(2'(p), 32'h0000_0020, 32'h0000_0002);
        end
        run(16'h1235, 32'h0000_0205);
        errChk(2'd0, 32'h0000_0020, 32'h0000_0002);
    endtask
    task automatic sCwErr();
        run(16'h1234, 32'h0000_0225);
        chk(32'(caps.size()), 32'h0000_0001);
        chk(32'({caps[0].shortForm, caps[0].data}), 32'h0001_0000);
        errChk(2'd0, 32'h0000_0001, 32'h0000_0002);
        i_rad_card_model.pins(1'b0, 1'b0, 1'b1);
        run(16'h1234, 32'h0000_0285);
        errChk(2'd2, 32'h0000_0004, 32'h0000_0002);
        i_rad_card_model.pins(1'b0, 1'b1, 1'b0);
        run(16'h1234, 32'h0000_02C1);
        i_rad_card_model.pins(1'b0, 1'b0, 1'b0);
        chk(32'({caps.size(), caps[0].shortForm}), 32'h0000_0003);
        errChk(2'd3, 32'h0000_0008, 32'h0000_0002);
    endtask
    task automatic sTimeout();
        caps.delete();
        bus(1'b1, `RAD_OFF_DATABUF, 32'h0000_A5A5);
        bus(1'b1, `RAD_OFF_CTRL, 32'h0000_0211);
        i_rad_card_model.word(16'h1234, 2'b11, 1'b0, 1'b0);
        idle();
        chk(32'(caps.size()), 32'h0000_0001);
        errChk(2'd0, 32'h0000_0002, 32'h0000_0002);
        rdc(`RAD_OFF_DATABUF, 32'h0000_A5A5);
        rdc(`RAD_OFF_EXTBUF, ZW);
    endtask
    // errors in the data phase need a clean control word first; position 0 ignores type 1
    task automatic sExt();
        for (int p = 0; p < 4; p++) begin
            caps.delete();
            i_rad_card_model.pins(1'b1, 1'b0, 1'b0);
            bus(1'b1, `RAD_OFF_CTRL, 32'h0000_0201 | 32'(p << 6));
            i_rad_card_model.word(16'h1234, 2'b11, 1'b0, 1'b0);
            if (p == 0) i_rad_card_model.pins(1'b1, 1'b0, 1'b1);
            idle();
            i_rad_card_model.pins(1'b0, 1'b0, 1'b0);
            chk(32'(caps.size()), 32'h0000_0001);
            errChk(2'(p), (p != 0) ? 32'h0000_0010 : 32'h0000_0004,
                32'h0000_0002);
        end
    endtask
    task automatic sTdPar();
        bus(1'b1, `RAD_OFF_CTRL, 32'h0000_0281);
        i_rad_card_model.word(16'h1234, 2'b11, 1'b0, 1'b0);
        i_rad_card_model.word(16'h5678, 2'b11, 1'b1, 1'b1);
        idle();
        rdc(`RAD_OFF_L1, 32'h0000_0006);
        rdc(`RAD_OFF_L2_2, ZW);
        rdc(`RAD_OFF_IRQST, 32'h0000_0001);
        bus(1'b1, `RAD_OFF_IRQMASK, 32'h0000_000E);
        chk(32'(irq), ZW);
        bus(1'b1, `RAD_OFF_IRQMASK, 32'h0000_000F);
        chk(32'(irq), 32'h0000_0001);
        bus(1'b1, `RAD_OFF_IRQST, 32'h0000_0001);
        chk(32'(irq), ZW);
    endtask
    task automatic sMaint();
        bus(1'b1, `RAD_OFF_ROUTE, 32'h0000_0001);
        i_rad_card_model.pins(1'b0, 1'b0, 1'b1);
        run(16'h1234, 32'h0000_0205);
        i_rad_card_model.pins(1'b0, 1'b0, 1'b0);
        rdc(`RAD_OFF_MAINT, 32'h0000_0001);
        rdc(`RAD_OFF_COMPL, 32'h0000_0041);
        rdc(`RAD_OFF_MAINT, ZW);
        errChk(2'd0, 32'h0000_0004, 32'h0000_0006);
        bus(1'b1, `RAD_OFF_ROUTE, 32'h0000_0011);
        bus(1'b1, `RAD_OFF_CTRL, 32'h0000_0002);
        rdc(`RAD_OFF_IRQST, 32'h0000_0008);
        rdc(`RAD_OFF_COMPL, 32'h0000_0080);
        bus(1'b1, `RAD_OFF_CTRL, ZW);
        bus(1'b1, `RAD_OFF_IRQST, 32'h0000_0008);
        chk(32'(irq), ZW);
    endtask
    initial begin
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        sRegs();
        sWrap();
        sStrobe();
        sCwErr();
        sTimeout();
        sExt();
        sTdPar();
        sMaint();
        conclude();
    end
    // whole run needs under a thousand cycles
    initial begin
        repeat (20000) @(posedge mclk);
        fail_count++;
        conclude();
    end
endmodule
